// File: core/ucsd_pkg.sv
/*
  constants for the uart clock, status and detect block: register offsets,
  field positions, reset values and widths.
  assumes a 32-bit apb slave with byte addresses on an 8-bit offset.
*/
package ucsd_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LINE_STATUS = 8'h1c;
  localparam logic [7:0] OFS_LOW_PULSE = 8'h28;
  localparam logic [7:0] OFS_HIGH_PULSE = 8'h2c;
  localparam logic [7:0] OFS_EDGE_COUNT = 8'h30;
  localparam logic [7:0] OFS_PRE_IDLE = 8'h50;
  localparam logic [7:0] OFS_POST_IDLE = 8'h54;
  localparam logic [7:0] OFS_GAP_TOUT = 8'h58;
  localparam logic [7:0] OFS_CMD_CHAR = 8'h5c;
  localparam logic [7:0] OFS_TX_PTRS = 8'h64;
  localparam logic [7:0] OFS_RX_PTRS = 8'h68;
  localparam logic [7:0] OFS_FSM_STATUS = 8'h6c;
  localparam logic [7:0] OFS_RISE_INTV = 8'h70;
  localparam logic [7:0] OFS_FALL_INTV = 8'h74;
  localparam logic [7:0] OFS_CLK_CONF = 8'h78;
  localparam logic [7:0] OFS_VERSION = 8'h7c;
  localparam logic [7:0] OFS_ID_SYNC = 8'h80;

  // ---------------------------------------------------------------
  // core_clock_config fields
  // ---------------------------------------------------------------
  localparam int CC_DEN_LSB = 0;
  localparam int CC_NUMER_LSB = 6;
  localparam int CC_INT_LSB = 12;
  localparam int CC_SEL_LSB = 20;
  localparam int CC_SCLK_EN = 22;
  localparam int CC_RST_CORE = 23;
  localparam int CC_TX_EN = 24;
  localparam int CC_RX_EN = 25;
  localparam int CC_TX_RST = 26;
  localparam int CC_RX_RST = 27;
  localparam int CC_USED = 28;

  // ---------------------------------------------------------------
  // other field positions
  // ---------------------------------------------------------------
  localparam int ST_DSR = 13;
  localparam int ST_CTS = 14;
  localparam int ST_RXD = 15;
  localparam int ST_TXCNT_LSB = 16;
  localparam int ST_DTR = 29;
  localparam int ST_RTS = 30;
  localparam int ST_TXD = 31;
  localparam int PTR_HI_LSB = 11;
  localparam int FSM_TX_LSB = 4;
  localparam int CHAR_NUM_LSB = 8;
  localparam int ID_UPD_CTRL = 30;
  localparam int ID_REG_UPD = 31;

  // ---------------------------------------------------------------
  // reset values and instance bases
  // ---------------------------------------------------------------
  localparam logic [31:0] CLK_CONF_RST = 32'h0370_1000;
  localparam logic [15:0] PRE_IDLE_RST = 16'h0008;
  localparam logic [15:0] POST_IDLE_RST = 16'h0008;
  localparam logic [15:0] GAP_TOUT_RST = 16'h000b;
  localparam logic [15:0] CMD_CHAR_RST = 16'h0300;
  localparam logic [31:0] VERSION_RST = 32'h0000_0001;
  localparam logic [29:0] ID_RST = 30'h0000_0000;
  localparam logic [15:0] MEAS_MAX = 16'hffff;
  localparam logic [9:0] RX_BASE_U0 = 10'h200;
  localparam logic [9:0] RX_BASE_U1 = 10'h280;
  localparam logic [9:0] RX_BASE_U2 = 10'h300;

  typedef enum logic [1:0] {
    CMD_WAIT = 2'b00,
    CMD_COUNT = 2'b01,
    CMD_POST = 2'b10
  } ucsd_cmd_t;

endpackage : ucsd_pkg

// File: core/ucsd_top.sv
/*
  uart clock configuration, status readout and rx detect logic behind apb.
  assumes one clock i_clk; line pins arrive asynchronous, all other
  status inputs come from uart core logic on the same clock.
*/
module ucsd_top #(
  parameter logic [9:0] RX_POS_BASE = ucsd_pkg::RX_BASE_U0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // asynchronous line pins
  input wire logic i_rxd_pin,
  input wire logic i_dsr_pin,
  input wire logic i_cts_pin,
  // core levels and status
  input wire logic i_dtr_level,
  input wire logic i_rts_level,
  input wire logic i_txd_level,
  input wire logic [9:0] i_rx_fill_count,
  input wire logic [9:0] i_tx_fill_count,
  input wire logic [9:0] i_tx_sw_write_pos,
  input wire logic [9:0] i_tx_fsm_read_pos,
  input wire logic [6:0] i_rx_sw_read_pos,
  input wire logic [6:0] i_rx_ctrl_write_pos,
  input wire logic [3:0] i_receiver_state,
  input wire logic [3:0] i_transmitter_state,
  // received byte stream
  input wire logic i_bit_tick,
  input wire logic i_rx_byte_valid,
  input wire logic [7:0] i_rx_byte,
  // core clocking and detect
  output logic [1:0] o_clk_sel,
  output logic o_core_tick,
  output logic o_tx_tick,
  output logic o_rx_tick,
  output logic o_tx_rst,
  output logic o_rx_rst,
  output logic o_cmd_detect
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      ucsd_pkg::OFS_LINE_STATUS, ucsd_pkg::OFS_LOW_PULSE, ucsd_pkg::OFS_HIGH_PULSE,
      ucsd_pkg::OFS_EDGE_COUNT, ucsd_pkg::OFS_PRE_IDLE, ucsd_pkg::OFS_POST_IDLE,
      ucsd_pkg::OFS_GAP_TOUT, ucsd_pkg::OFS_CMD_CHAR, ucsd_pkg::OFS_TX_PTRS,
      ucsd_pkg::OFS_RX_PTRS, ucsd_pkg::OFS_FSM_STATUS, ucsd_pkg::OFS_RISE_INTV,
      ucsd_pkg::OFS_FALL_INTV, ucsd_pkg::OFS_CLK_CONF, ucsd_pkg::OFS_VERSION,
      ucsd_pkg::OFS_ID_SYNC: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == ucsd_pkg::MEAS_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [31:0] clk_conf;
  logic [15:0] pre_idle;
  logic [15:0] post_idle;
  logic [15:0] gap_tout;
  logic [15:0] cmd_char;
  logic [31:0] version;
  logic [29:0] inst_id;
  logic upd_ctrl;
  logic reg_update;
  logic upd_req;
  logic upd_ack;
  logic wr;
  logic [31:0] next_prdata;
  logic [2:0] dsr_sync;
  logic [2:0] cts_sync;
  logic [2:0] rxd_sync;
  logic [15:0] low_min;
  logic [15:0] high_max;
  logic [9:0] edge_cnt;
  logic [15:0] rise_min;
  logic [15:0] fall_min;

  assign wr = i_psel && i_penable && i_pwrite && addr_hit(i_paddr);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit(i_paddr);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      clk_conf <= ucsd_pkg::CLK_CONF_RST;
      pre_idle <= ucsd_pkg::PRE_IDLE_RST;
      post_idle <= ucsd_pkg::POST_IDLE_RST;
      gap_tout <= ucsd_pkg::GAP_TOUT_RST;
      cmd_char <= ucsd_pkg::CMD_CHAR_RST;
      version <= ucsd_pkg::VERSION_RST;
      inst_id <= ucsd_pkg::ID_RST;
      upd_ctrl <= 1'b0;
    end
    else if (wr)
    begin
      case (i_paddr)
        ucsd_pkg::OFS_CLK_CONF: clk_conf <= {4'h0, i_pwdata[ucsd_pkg::CC_USED-1:0]};
        ucsd_pkg::OFS_PRE_IDLE: pre_idle <= i_pwdata[15:0];
        ucsd_pkg::OFS_POST_IDLE: post_idle <= i_pwdata[15:0];
        ucsd_pkg::OFS_GAP_TOUT: gap_tout <= i_pwdata[15:0];
        ucsd_pkg::OFS_CMD_CHAR: cmd_char <= i_pwdata[15:0];
        ucsd_pkg::OFS_VERSION: version <= i_pwdata;
        ucsd_pkg::OFS_ID_SYNC:
        begin
          inst_id <= i_pwdata[29:0];
          upd_ctrl <= i_pwdata[ucsd_pkg::ID_UPD_CTRL];
        end
        default: version <= version;
      endcase
    end
  end

  // read data is captured in the setup cycle, so every access ends at once
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (i_paddr)
      ucsd_pkg::OFS_LINE_STATUS: next_prdata = {i_txd_level, i_rts_level, i_dtr_level,
        3'h0, i_tx_fill_count, rxd_sync[2], cts_sync[2], dsr_sync[2], 3'h0,
        i_rx_fill_count};
      ucsd_pkg::OFS_LOW_PULSE: next_prdata = {16'h0000, low_min};
      ucsd_pkg::OFS_HIGH_PULSE: next_prdata = {16'h0000, high_max};
      ucsd_pkg::OFS_EDGE_COUNT: next_prdata = {22'h00_0000, edge_cnt};
      ucsd_pkg::OFS_PRE_IDLE: next_prdata = {16'h0000, pre_idle};
      ucsd_pkg::OFS_POST_IDLE: next_prdata = {16'h0000, post_idle};
      ucsd_pkg::OFS_GAP_TOUT: next_prdata = {16'h0000, gap_tout};
      ucsd_pkg::OFS_CMD_CHAR: next_prdata = {16'h0000, cmd_char};
      ucsd_pkg::OFS_TX_PTRS: next_prdata = {11'h000, i_tx_fsm_read_pos, 1'b0,
        i_tx_sw_write_pos};
      ucsd_pkg::OFS_RX_PTRS: next_prdata = {11'h000,
        RX_POS_BASE + {3'h0, i_rx_ctrl_write_pos}, 1'b0,
        RX_POS_BASE + {3'h0, i_rx_sw_read_pos}};
      ucsd_pkg::OFS_FSM_STATUS: next_prdata = {24'h00_0000, i_transmitter_state,
        i_receiver_state};
      ucsd_pkg::OFS_RISE_INTV: next_prdata = {16'h0000, rise_min};
      ucsd_pkg::OFS_FALL_INTV: next_prdata = {16'h0000, fall_min};
      ucsd_pkg::OFS_CLK_CONF: next_prdata = clk_conf;
      ucsd_pkg::OFS_VERSION: next_prdata = version;
      ucsd_pkg::OFS_ID_SYNC: next_prdata = {reg_update, upd_ctrl, inst_id};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable)
      o_prdata <= next_prdata;
  end

  // ---------------------------------------------------------------
  // update handshake into core settings
  // ---------------------------------------------------------------
  logic [31:0] sh_clk;
  logic [15:0] sh_pre;
  logic [15:0] sh_post;
  logic [15:0] sh_gap;
  logic [15:0] sh_char;
  logic load;

  assign load = upd_ctrl || upd_ack;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      reg_update <= 1'b0;
      upd_req <= 1'b0;
      upd_ack <= 1'b0;
    end
    else
    begin
      upd_req <= reg_update && !upd_ack;
      upd_ack <= upd_req && !upd_ack;
      // a software set in the clearing cycle wins
      if (wr && i_paddr == ucsd_pkg::OFS_ID_SYNC && i_pwdata[ucsd_pkg::ID_REG_UPD])
        reg_update <= 1'b1;
      else if (upd_ack)
        reg_update <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sh_clk <= ucsd_pkg::CLK_CONF_RST;
      sh_pre <= ucsd_pkg::PRE_IDLE_RST;
      sh_post <= ucsd_pkg::POST_IDLE_RST;
      sh_gap <= ucsd_pkg::GAP_TOUT_RST;
      sh_char <= ucsd_pkg::CMD_CHAR_RST;
    end
    else if (load)
    begin
      sh_clk <= clk_conf;
      sh_pre <= pre_idle;
      sh_post <= post_idle;
      sh_gap <= gap_tout;
      sh_char <= cmd_char;
    end
  end

  // ---------------------------------------------------------------
  // fractional divider, gating and resets
  // ---------------------------------------------------------------
  logic [7:0] div_int;
  logic [5:0] div_a;
  logic [5:0] div_b;
  logic [7:0] div_cnt;
  logic [5:0] frac_acc;
  logic [6:0] frac_sum;
  logic extra;
  logic [8:0] div_last;
  logic div_done;

  assign div_int = sh_clk[ucsd_pkg::CC_INT_LSB +: 8];
  assign div_a = sh_clk[ucsd_pkg::CC_NUMER_LSB +: 6];
  assign div_b = sh_clk[ucsd_pkg::CC_DEN_LSB +: 6];
  assign frac_sum = {1'b0, frac_acc} + {1'b0, div_a};
  assign div_last = (div_int == 8'h00) ? {8'h00, extra} :
                    {1'b0, div_int} - 9'h001 + {8'h00, extra};
  assign div_done = {1'b0, div_cnt} >= div_last;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      div_cnt <= 8'h00;
      frac_acc <= 6'h00;
      extra <= 1'b0;
    end
    else if (div_done)
    begin
      div_cnt <= 8'h00;
      // numerator at or above denominator counts as no fraction
      if (div_b != 6'h00 && div_a < div_b && frac_sum >= {1'b0, div_b})
      begin
        frac_acc <= 6'(frac_sum - {1'b0, div_b});
        extra <= 1'b1;
      end
      else
      begin
        frac_acc <= (div_a < div_b) ? frac_sum[5:0] : 6'h00;
        extra <= 1'b0;
      end
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_clk_sel <= ucsd_pkg::CLK_CONF_RST[ucsd_pkg::CC_SEL_LSB +: 2];
      o_core_tick <= 1'b0;
      o_tx_tick <= 1'b0;
      o_rx_tick <= 1'b0;
      o_tx_rst <= 1'b1;
      o_rx_rst <= 1'b1;
    end
    else
    begin
      o_clk_sel <= sh_clk[ucsd_pkg::CC_SEL_LSB +: 2];
      o_core_tick <= div_done && sh_clk[ucsd_pkg::CC_SCLK_EN];
      o_tx_tick <= div_done && sh_clk[ucsd_pkg::CC_SCLK_EN] && sh_clk[ucsd_pkg::CC_TX_EN];
      o_rx_tick <= div_done && sh_clk[ucsd_pkg::CC_SCLK_EN] && sh_clk[ucsd_pkg::CC_RX_EN];
      o_tx_rst <= sh_clk[ucsd_pkg::CC_RST_CORE] || sh_clk[ucsd_pkg::CC_TX_RST];
      o_rx_rst <= sh_clk[ucsd_pkg::CC_RST_CORE] || sh_clk[ucsd_pkg::CC_RX_RST];
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and baud measurement
  // ---------------------------------------------------------------
  logic [15:0] low_run;
  logic [15:0] high_run;
  logic [15:0] rise_run;
  logic [15:0] fall_run;
  logic rise_seen;
  logic fall_seen;
  logic rxd_rise;
  logic rxd_fall;

  // bit 2 is a history copy of the synchronised level for edge detection
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      dsr_sync <= 3'h7;
      cts_sync <= 3'h7;
      rxd_sync <= 3'h7;
    end
    else
    begin
      dsr_sync <= {dsr_sync[1], dsr_sync[0], i_dsr_pin};
      cts_sync <= {cts_sync[1], cts_sync[0], i_cts_pin};
      rxd_sync <= {rxd_sync[1], rxd_sync[0], i_rxd_pin};
    end
  end

  assign rxd_rise = rxd_sync[1] && !rxd_sync[2];
  assign rxd_fall = !rxd_sync[1] && rxd_sync[2];

  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_rx_rst)
    begin
      low_run <= 16'h0000;
      high_run <= 16'h0000;
      rise_run <= 16'h0000;
      fall_run <= 16'h0000;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
      low_min <= ucsd_pkg::MEAS_MAX;
      high_max <= 16'h0000;
      edge_cnt <= 10'h000;
      rise_min <= ucsd_pkg::MEAS_MAX;
      fall_min <= ucsd_pkg::MEAS_MAX;
    end
    else
    begin
      low_run <= rxd_sync[1] ? 16'h0000 : sat_inc(low_run);
      high_run <= rxd_sync[1] ? sat_inc(high_run) : 16'h0000;
      rise_run <= rxd_rise ? 16'h0001 : sat_inc(rise_run);
      fall_run <= rxd_fall ? 16'h0001 : sat_inc(fall_run);
      if (rxd_rise || rxd_fall)
        edge_cnt <= edge_cnt + 10'h001;
      if (rxd_rise)
      begin
        rise_seen <= 1'b1;
        if (low_run != 16'h0000 && low_run < low_min)
          low_min <= low_run;
        if (rise_seen && rise_run < rise_min)
          rise_min <= rise_run;
      end
      if (rxd_fall)
      begin
        fall_seen <= 1'b1;
        if (high_run > high_max)
          high_max <= high_run;
        if (fall_seen && fall_run < fall_min)
          fall_min <= fall_run;
      end
    end
  end

  // ---------------------------------------------------------------
  // repeated command character detection
  // ---------------------------------------------------------------
  ucsd_pkg::ucsd_cmd_t cmd_state;
  logic [15:0] idle_bits;
  logic [7:0] char_cnt;
  logic match;

  assign match = i_rx_byte == sh_char[7:0];

  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_rx_rst)
      idle_bits <= 16'h0000;
    else if (i_rx_byte_valid)
      idle_bits <= 16'h0000;
    else if (i_bit_tick)
      idle_bits <= sat_inc(idle_bits);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_rx_rst)
    begin
      cmd_state <= ucsd_pkg::CMD_WAIT;
      char_cnt <= 8'h00;
      o_cmd_detect <= 1'b0;
    end
    else
    begin
      o_cmd_detect <= 1'b0;
      case (cmd_state)
        ucsd_pkg::CMD_WAIT:
          if (i_rx_byte_valid && match && idle_bits >= sh_pre)
          begin
            char_cnt <= 8'h01;
            cmd_state <= (sh_char[15:8] <= 8'h01) ? ucsd_pkg::CMD_POST : ucsd_pkg::CMD_COUNT;
          end
        ucsd_pkg::CMD_COUNT:
          if (i_rx_byte_valid && match && idle_bits <= sh_gap)
          begin
            char_cnt <= char_cnt + 8'h01;
            if (char_cnt + 8'h01 >= sh_char[15:8])
              cmd_state <= ucsd_pkg::CMD_POST;
          end
          else if (i_rx_byte_valid || idle_bits > sh_gap)
            cmd_state <= ucsd_pkg::CMD_WAIT;
        ucsd_pkg::CMD_POST:
          if (i_rx_byte_valid)
            cmd_state <= ucsd_pkg::CMD_WAIT;
          else if (idle_bits >= sh_post)
          begin
            o_cmd_detect <= 1'b1;
            cmd_state <= ucsd_pkg::CMD_WAIT;
          end
        default: cmd_state <= ucsd_pkg::CMD_WAIT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_update_clears: assert property ($rose(upd_req) |=> ##1 !reg_update || $past(wr))
    else $error("update request not cleared");
  a_manual_hold: assert property (!upd_ctrl && !upd_ack |=> $stable(sh_clk))
    else $error("settings moved without request");
  a_auto_follow: assert property (upd_ctrl |=> sh_clk == $past(clk_conf))
    else $error("auto mode did not copy settings");
  a_core_reset: assert property (sh_clk[ucsd_pkg::CC_RST_CORE] |=> o_tx_rst && o_rx_rst)
    else $error("core reset not applied to both paths");
  a_rx_reset_only: assert property (sh_clk[ucsd_pkg::CC_RX_RST] && !sh_clk[ucsd_pkg::CC_RST_CORE]
    && !sh_clk[ucsd_pkg::CC_TX_RST] |=> o_rx_rst && !o_tx_rst)
    else $error("rx reset leaked to tx");
  a_tx_gate: assert property (!sh_clk[ucsd_pkg::CC_TX_EN] |=> !o_tx_tick)
    else $error("tx tick while gated");
  a_core_gate: assert property (!sh_clk[ucsd_pkg::CC_SCLK_EN] |=> !o_core_tick && !o_rx_tick)
    else $error("core tick while gated");
  a_low_min_falls: assert property (!o_rx_rst && !$past(o_rx_rst) |-> low_min <= $past(low_min))
    else $error("low pulse minimum grew");
  a_edge_step: assert property (rxd_rise && !o_rx_rst |=> edge_cnt == 10'($past(edge_cnt) + 1))
    else $error("edge not counted");
  a_detect_cause: assert property (o_cmd_detect |-> $past(cmd_state) == ucsd_pkg::CMD_POST
    && $past(idle_bits) >= $past(sh_post))
    else $error("detect without post idle");

  c_detect: cover property (o_cmd_detect);
  c_update_done: cover property ($fell(reg_update));
  c_frac_extra: cover property (div_done && extra);
  c_edge_min: cover property (rxd_rise && rise_seen);

endmodule : ucsd_top

// File: testbench/ucsd_remote_line.sv
/*
  remote serial device model: drives the rx line with timed pulses.
  assumes a go pulse of one cycle, with both lengths held stable.
*/
module ucsd_remote_line (
  // clock and control
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_low_len,
  input wire logic [7:0] i_high_len,
  // serial line, idles at mark level
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_rxd = 1'b1;
  // ----------------------------------------
  // low, high, low, then back to idle
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      o_rxd <= 1'b0;
      repeat (i_low_len) @(posedge i_clk);
      o_rxd <= 1'b1;
      repeat (i_high_len) @(posedge i_clk);
      o_rxd <= 1'b0;
      repeat (i_low_len) @(posedge i_clk);
      o_rxd <= 1'b1;
    end
  end
endmodule : ucsd_remote_line

// File: testbench/tb_uart_clock_status_detect.sv
/*
  self-checking bench for the uart clock, status and detect block.
  assumes the design package and the remote line model are compiled first.
*/
module tb_uart_clock_status_detect;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic [7:0] i_paddr = 8'h00, i_rx_byte = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, i_rxd_pin, i_dsr_pin = 0, i_cts_pin = 0;
  logic i_dtr_level = 1, i_rts_level = 0, i_txd_level = 1;
  logic [9:0] i_rx_fill_count = 10'h023, i_tx_fill_count = 10'h011;
  logic [9:0] i_tx_sw_write_pos = 10'h005, i_tx_fsm_read_pos = 10'h00a;
  logic [6:0] i_rx_sw_read_pos = 7'h03, i_rx_ctrl_write_pos = 7'h07;
  logic [3:0] i_receiver_state = 4'h6, i_transmitter_state = 4'h9;
  logic i_bit_tick = 0, i_rx_byte_valid = 0, go = 0;
  logic [1:0] o_clk_sel;
  logic o_core_tick, o_tx_tick, o_rx_tick, o_tx_rst, o_rx_rst, o_cmd_detect;
  int n_fail = 0, tests_run = 0, n_det = 0, n_tx = 0, n_rx = 0, n_core = 0, g, h;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} ucsd_row_t;
  ucsd_row_t rows [12] = '{'{8'h64, 32'h0000_5005, 1'b0}, '{8'h1c, 32'ha011_8023, 1'b0},
    '{8'h68, 32'h0010_3a03, 1'b0}, '{8'h6c, 32'h0000_0096, 1'b0},
    '{8'h50, 32'h8, 1'b0}, '{8'h54, 32'h8, 1'b0}, '{8'h58, 32'hb, 1'b0},
    '{8'h5c, 32'h300, 1'b0}, '{8'h7c, 32'h1, 1'b0}, '{8'h78, 32'h0370_1000, 1'b0},
    '{8'h80, 32'h0, 1'b0}, '{8'h84, 32'h0, 1'b1}};
  logic [33:0] rs [4] = '{{2'b10, 32'h0400_0000}, {2'b01, 32'h0800_0000},
    {2'b11, 32'h0080_0000}, {2'b00, 32'h0}};

  ucsd_top #(.RX_POS_BASE(ucsd_pkg::RX_BASE_U0)) uut (.*);
  ucsd_remote_line far (.i_clk(i_clk), .i_go(go), .i_low_len(8'h05),
    .i_high_len(8'h09), .o_rxd(i_rxd_pin));

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    n_det += (o_cmd_detect === 1'b1);
    n_tx += (o_tx_tick === 1'b1);
    n_rx += (o_rx_tick === 1'b1);
    n_core += (o_core_tick === 1'b1);
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (o_pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      close_out();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge i_clk) i_bit_tick <= 1'b1;
      @(posedge i_clk) i_bit_tick <= 1'b0;
    end
  endtask : ticks

  task automatic sendb(input logic [7:0] b);
    @(posedge i_clk);
    i_rx_byte_valid <= 1'b1;
    i_rx_byte <= b;
    @(posedge i_clk) i_rx_byte_valid <= 1'b0;
  endtask : sendb

  task automatic cmd(input int pre, input int gp, input logic [31:0] exp);
    int n0;
    n0 = n_det;
    sendb(8'h41);
    ticks(pre);
    sendb(8'h00);
    ticks(gp);
    sendb(8'h00);
    ticks(2);
    sendb(8'h00);
    ticks(10);
    chk(n_det - n0, exp, "command detect");
  endtask : cmd

  task automatic gap(output int n);
    int k;
    k = 0;
    n = 0;
    while (o_core_tick !== 1'b1 && k < 40)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 40)
    begin
      n_fail++;
      close_out();
    end
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_core_tick !== 1'b1 && n < 40);
  endtask : gap

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d, "register read");
      chk(err, rows[i].e, "slave error");
    end
    apb(1'b1, ucsd_pkg::OFS_TX_PTRS, 32'hffff_ffff);
    apb(1'b0, ucsd_pkg::OFS_TX_PTRS, 32'h0);
    chk(rd, 32'h0000_5005, "read-only write");
    $display("table and access test done");
    @(posedge i_clk) go <= 1'b1;
    @(posedge i_clk) go <= 1'b0;
    repeat (40) @(posedge i_clk);
    apb(1'b0, ucsd_pkg::OFS_EDGE_COUNT, 32'h0);
    chk(rd, 32'h4, "edge count");
    apb(1'b0, ucsd_pkg::OFS_LOW_PULSE, 32'h0);
    chk(rd, 32'h5, "low pulse");
    apb(1'b0, ucsd_pkg::OFS_HIGH_PULSE, 32'h0);
    chk(rd, 32'h2d, "high pulse");
    apb(1'b0, ucsd_pkg::OFS_RISE_INTV, 32'h0);
    chk(rd, 32'he, "rise interval");
    apb(1'b0, ucsd_pkg::OFS_FALL_INTV, 32'h0);
    chk(rd, 32'he, "fall interval");
    cmd(9, 2, 32'h1);
    cmd(3, 2, 32'h0);
    cmd(9, 14, 32'h0);
    $display("line measure and detect tests done");
    apb(1'b1, ucsd_pkg::OFS_CLK_CONF, 32'h0350_4000);
    repeat (6) @(posedge i_clk);
    chk(o_clk_sel, 32'h3, "held without update");
    apb(1'b1, ucsd_pkg::OFS_ID_SYNC, 32'h8000_0000);
    rd = 32'hffff_ffff;
    g = 0;
    while (rd[31] !== 1'b0 && g < 20)
    begin
      apb(1'b0, ucsd_pkg::OFS_ID_SYNC, 32'h0);
      g++;
    end
    chk(g < 20, 32'h1, "update bit clear");
    repeat (2) @(posedge i_clk);
    chk(o_clk_sel, 32'h1, "bus clock select");
    gap(g);
    chk(g, 32'h4, "integer period");
    apb(1'b1, ucsd_pkg::OFS_ID_SYNC, 32'h4000_0000);
    apb(1'b1, ucsd_pkg::OFS_CLK_CONF, 32'h0260_4042);
    repeat (4) @(posedge i_clk);
    chk(o_clk_sel, 32'h2, "auto sync select");
    gap(g);
    gap(h);
    chk(g + h, 32'h9, "fractional period");
    g = n_tx;
    h = n_rx;
    repeat (20) @(posedge i_clk);
    chk({n_tx == g, n_rx > h}, 32'h3, "path gating");
    apb(1'b1, ucsd_pkg::OFS_CLK_CONF, 32'h0220_4042);
    repeat (4) @(posedge i_clk);
    g = n_core;
    repeat (20) @(posedge i_clk);
    chk(n_core - g, 32'h0, "core gate");
    $display("clock tests done");
    foreach (rs[i])
    begin
      apb(1'b1, ucsd_pkg::OFS_CLK_CONF, rs[i][31:0]);
      repeat (4) @(posedge i_clk);
      chk({o_tx_rst, o_rx_rst}, rs[i][33:32], "path reset");
    end
    @(posedge i_clk) i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    apb(1'b0, ucsd_pkg::OFS_CLK_CONF, 32'h0);
    chk(rd, ucsd_pkg::CLK_CONF_RST, "reset value");
    chk(o_clk_sel, 32'h3, "reset select");
    $display("reset tests done");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    close_out();
  end
endmodule : tb_uart_clock_status_detect
